// ---- src/scciu_pkg.sv ----
// package: constants and types for the system control instruction unit
package scciu_pkg;

    // ----------------------------------------------------------------
    // widths
    // ----------------------------------------------------------------
    localparam int PC_W   = 10;
    localparam int SP_W   = 8;
    localparam int DATA_W = 8;

    // ----------------------------------------------------------------
    // reset values and step sizes
    // ----------------------------------------------------------------
    localparam logic [PC_W-1:0] PC_RST      = 10'h000;
    localparam logic [SP_W-1:0] SP_RST      = 8'h00;
    localparam logic [SP_W-1:0] SP_STEP     = 8'h02;
    localparam logic [PC_W-1:0] PC_STEP     = 10'h001;
    localparam logic            GIE_RST     = 1'b0;
    localparam logic [1:0]      LONG_CYCLES = 2'h2;

    // ----------------------------------------------------------------
    // decoded operation codes
    // ----------------------------------------------------------------
    typedef enum logic [3:0] {
        OP_NOP     = 4'b0000,
        OP_CALL    = 4'b0001,
        OP_JUMP    = 4'b0010,
        OP_RET_IMM = 4'b0011,
        OP_RET     = 4'b0100,
        OP_RETI    = 4'b0101,
        OP_PCADD   = 4'b0110,
        OP_GIE_ON  = 4'b0111,
        OP_GIE_OFF = 4'b1000,
        OP_HALT_SYS= 4'b1001,
        OP_HALT_CPU= 4'b1010,
        OP_SW_RST  = 4'b1011,
        OP_WDT_CLR = 4'b1100
    } scciu_op_t;

    // ----------------------------------------------------------------
    // execution states
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_FETCH  = 2'b00,
        ST_SECOND = 2'b01,
        ST_HALT   = 2'b10
    } scciu_state_t;

    // instruction handed in from the fetch stage
    typedef struct packed {
        scciu_op_t           op;
        logic [PC_W-1:0]     target;
        logic [DATA_W-1:0]   imm;
    } scciu_instr_t;

    // stack memory port
    typedef struct packed {
        logic                we;
        logic [SP_W-1:0]     addr;
        logic [PC_W-1:0]     wdata;
    } scciu_stack_t;

endpackage : scciu_pkg

// ---- src/scciu_top.sv ----
// system control instruction unit: flow control, interrupt enable, halt, reset
// Functional notes
// - call stores pc+1 at [sp], jumps to target, sp grows by two.
// - jump loads pc with the full-range target address.
// - return with immediate loads the byte into accumulator, then returns.
// - return drops sp by two then loads pc from [sp].
// - interrupt return restores pc like return and sets global enable.
// - computed jump sets pc to pc plus accumulator.
// - enable instruction sets global interrupt enable.
// - disable instruction clears global interrupt enable.
// - full halt stops all clocks including oscillators.
// - processor halt gates system clock, oscillators keep running.
// - software reset resets whole chip like hardware reset.
// - watchdog restart clears the watchdog count.
// - no flag changes; nop only advances execution.
// - jump, call, computed jump, returns take two cycles; others one.
`timescale 1ns/100ps
module scciu_top (
    // clock and reset
    input  wire logic                          i_ref_clk,
    input  wire logic                          i_resetn,
    // instruction stream
    input  wire scciu_pkg::scciu_instr_t       i_instr,
    input  wire logic                          i_instr_valid,
    input  wire logic [scciu_pkg::DATA_W-1:0]  i_acc,
    // stack memory read data
    input  wire logic [scciu_pkg::PC_W-1:0]    i_stack_rdata,
    // wake-up request
    input  wire logic                          i_wake,
    // program flow outputs
    output logic [scciu_pkg::PC_W-1:0]         o_pc,
    output logic [scciu_pkg::SP_W-1:0]         o_sp,
    output scciu_pkg::scciu_stack_t            o_stack,
    output logic                               o_busy,
    // accumulator write
    output logic                               o_acc_we,
    output logic [scciu_pkg::DATA_W-1:0]       o_acc_wdata,
    // system control
    output logic                               o_gie,
    output logic                               o_sys_clk_en,
    output logic                               o_osc_en,
    output logic                               o_chip_rst,
    output logic                               o_wdt_clr,
    output logic                               o_flags_we
);

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    scciu_pkg::scciu_state_t          state_r;
    scciu_pkg::scciu_op_t             op_r;
    logic                             halt_sys_r;
    logic [scciu_pkg::PC_W-1:0]       pc_r;
    logic [scciu_pkg::SP_W-1:0]       sp_r;
    logic                             take;
    logic                             is_long;
    logic                             is_ret;

    // the three return kinds share the second-cycle stack read
    function automatic logic is_return(input scciu_pkg::scciu_op_t op);
        is_return = (op == scciu_pkg::OP_RET) || (op == scciu_pkg::OP_RETI)
                    || (op == scciu_pkg::OP_RET_IMM);
    endfunction

    assign take    = (state_r == scciu_pkg::ST_FETCH) && i_instr_valid;
    assign is_ret  = is_return(i_instr.op);
    assign is_long = is_ret || (i_instr.op == scciu_pkg::OP_CALL)
                   || (i_instr.op == scciu_pkg::OP_JUMP) || (i_instr.op == scciu_pkg::OP_PCADD);

    function automatic logic [scciu_pkg::PC_W-1:0] pc_inc(input logic [scciu_pkg::PC_W-1:0] p);
        pc_inc = p + scciu_pkg::PC_STEP;
    endfunction

    // ----------------------------------------------------------------
    // sequencer
    // ----------------------------------------------------------------
    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            state_r    <= scciu_pkg::ST_FETCH;
            op_r       <= scciu_pkg::OP_NOP;
            halt_sys_r <= 1'b0;
        end else begin
            case (state_r)
                scciu_pkg::ST_FETCH: begin
                    if (take) begin
                        op_r <= i_instr.op;
                        if (is_long) begin
                            state_r <= scciu_pkg::ST_SECOND;
                        end else if (i_instr.op == scciu_pkg::OP_HALT_SYS) begin
                            state_r    <= scciu_pkg::ST_HALT;
                            halt_sys_r <= 1'b1;
                        end else if (i_instr.op == scciu_pkg::OP_HALT_CPU) begin
                            state_r    <= scciu_pkg::ST_HALT;
                            halt_sys_r <= 1'b0;
                        end
                    end
                end
                scciu_pkg::ST_SECOND: state_r <= scciu_pkg::ST_FETCH;
                scciu_pkg::ST_HALT: begin
                    if (i_wake) begin
                        state_r    <= scciu_pkg::ST_FETCH;
                        halt_sys_r <= 1'b0;
                    end
                end
                default: state_r <= scciu_pkg::ST_FETCH;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // program counter and stack pointer
    // ----------------------------------------------------------------
    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            pc_r <= scciu_pkg::PC_RST;
            sp_r <= scciu_pkg::SP_RST;
        end else if (take) begin
            case (i_instr.op)
                scciu_pkg::OP_CALL: begin
                    pc_r <= i_instr.target;
                    sp_r <= sp_r + scciu_pkg::SP_STEP;
                end
                scciu_pkg::OP_JUMP:  pc_r <= i_instr.target;
                scciu_pkg::OP_PCADD: pc_r <= pc_r + {{(scciu_pkg::PC_W-scciu_pkg::DATA_W){1'b0}}, i_acc};
                scciu_pkg::OP_RET, scciu_pkg::OP_RETI, scciu_pkg::OP_RET_IMM:
                    sp_r <= sp_r - scciu_pkg::SP_STEP;
                default: pc_r <= pc_inc(pc_r);
            endcase
        end else if (state_r == scciu_pkg::ST_SECOND && is_return(op_r)) begin
            pc_r <= i_stack_rdata;
        end
    end

    // ----------------------------------------------------------------
    // stack port, accumulator write, pulses
    // ----------------------------------------------------------------
    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_stack     <= '0;
            o_acc_we    <= 1'b0;
            o_acc_wdata <= '0;
            o_chip_rst  <= 1'b0;
            o_wdt_clr   <= 1'b0;
        end else begin
            o_stack.we   <= take && (i_instr.op == scciu_pkg::OP_CALL);
            o_stack.addr <= (take && is_ret) ? sp_r - scciu_pkg::SP_STEP : sp_r;
            o_stack.wdata<= pc_inc(pc_r);
            o_acc_we     <= take && (i_instr.op == scciu_pkg::OP_RET_IMM);
            o_acc_wdata  <= i_instr.imm;
            o_chip_rst   <= take && (i_instr.op == scciu_pkg::OP_SW_RST);
            o_wdt_clr    <= take && (i_instr.op == scciu_pkg::OP_WDT_CLR);
        end
    end

    // ----------------------------------------------------------------
    // global interrupt enable
    // ----------------------------------------------------------------
    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_gie <= scciu_pkg::GIE_RST;
        end else if (take && i_instr.op == scciu_pkg::OP_GIE_ON) begin
            o_gie <= 1'b1;
        end else if (take && i_instr.op == scciu_pkg::OP_GIE_OFF) begin
            o_gie <= 1'b0;
        end else if (state_r == scciu_pkg::ST_SECOND && op_r == scciu_pkg::OP_RETI) begin
            o_gie <= 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // registered outputs
    // ----------------------------------------------------------------
    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_sys_clk_en <= 1'b1;
            o_osc_en     <= 1'b1;
            o_busy       <= 1'b0;
            o_flags_we   <= 1'b0;
        end else begin
            o_sys_clk_en <= !(take && (i_instr.op == scciu_pkg::OP_HALT_SYS
                              || i_instr.op == scciu_pkg::OP_HALT_CPU))
                            && !(state_r == scciu_pkg::ST_HALT && !i_wake);
            o_osc_en     <= !(take && i_instr.op == scciu_pkg::OP_HALT_SYS)
                            && !(halt_sys_r && state_r == scciu_pkg::ST_HALT && !i_wake);
            o_busy       <= take && is_long;
            o_flags_we   <= 1'b0;
        end
    end

    assign o_pc = pc_r;
    assign o_sp = sp_r;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    property p_call_sp;
        @(posedge i_ref_clk) disable iff (!i_resetn)
        take && i_instr.op == scciu_pkg::OP_CALL |=> sp_r == $past(sp_r) + scciu_pkg::SP_STEP;
    endproperty
    a_call_sp: assert property (p_call_sp) else $error("call did not grow sp by two");

    property p_jump;
        @(posedge i_ref_clk) disable iff (!i_resetn)
        take && i_instr.op == scciu_pkg::OP_JUMP |=> pc_r == $past(i_instr.target);
    endproperty
    a_jump: assert property (p_jump) else $error("jump target not loaded");

    property p_retimm;
        @(posedge i_ref_clk) disable iff (!i_resetn)
        take && i_instr.op == scciu_pkg::OP_RET_IMM |=> o_acc_we && o_acc_wdata == $past(i_instr.imm);
    endproperty
    a_retimm: assert property (p_retimm) else $error("immediate not written");

    property p_ret;
        @(posedge i_ref_clk) disable iff (!i_resetn)
        take && i_instr.op == scciu_pkg::OP_RET |=> state_r == scciu_pkg::ST_SECOND
            ##1 pc_r == $past(i_stack_rdata);
    endproperty
    a_ret: assert property (p_ret) else $error("return pc wrong");

    property p_reti;
        @(posedge i_ref_clk) disable iff (!i_resetn)
        take && i_instr.op == scciu_pkg::OP_RETI |=> ##1 o_gie;
    endproperty
    a_reti: assert property (p_reti) else $error("gie not set after reti");

    property p_pcadd;
        @(posedge i_ref_clk) disable iff (!i_resetn)
        take && i_instr.op == scciu_pkg::OP_PCADD |=> pc_r == $past(pc_r) + $past(i_acc);
    endproperty
    a_pcadd: assert property (p_pcadd) else $error("computed jump wrong");

    property p_gie_off;
        @(posedge i_ref_clk) disable iff (!i_resetn)
        take && i_instr.op == scciu_pkg::OP_GIE_OFF |=> !o_gie;
    endproperty
    a_gie_off: assert property (p_gie_off) else $error("gie not cleared");

    property p_halt;
        @(posedge i_ref_clk) disable iff (!i_resetn)
        take && i_instr.op == scciu_pkg::OP_HALT_CPU |=> !o_sys_clk_en && o_osc_en;
    endproperty
    a_halt: assert property (p_halt) else $error("cpu halt clocks wrong");

    c_call: cover property (@(posedge i_ref_clk) take && i_instr.op == scciu_pkg::OP_CALL);
    c_reti: cover property (@(posedge i_ref_clk) take && i_instr.op == scciu_pkg::OP_RETI);
    c_wake: cover property (@(posedge i_ref_clk) state_r == scciu_pkg::ST_HALT && i_wake);

endmodule // scciu_top

// ---- dv/scciu_stack_mem.sv ----
// stack memory model standing behind the instruction unit
`timescale 1ns/100ps
module scciu_stack_mem (
    // clock
    input  wire logic                     i_ref_clk,
    // stack port from the unit
    input  wire scciu_pkg::scciu_stack_t  i_stack,
    // read data back to the unit
    output logic [scciu_pkg::PC_W-1:0]    o_rdata
);
    logic [scciu_pkg::PC_W-1:0] mem_r [256];

    // unwritten words hold a varied pattern so a stale read cannot pass as zero
    initial begin
        for (int i = 0; i < 256; i++) begin
            mem_r[i] = 10'(i * 37 + 5);
        end
    end

    always @(posedge i_ref_clk) begin
        if (i_stack.we === 1'b1) begin
            mem_r[i_stack.addr] <= i_stack.wdata;
        end
    end

    // combinational read, as the unit expects
    assign o_rdata = mem_r[i_stack.addr];
endmodule // scciu_stack_mem

// ---- dv/tb.sv ----
// self-checking testbench for the system control instruction unit
`timescale 1ns/100ps
module tb;
    logic                              i_ref_clk = 1'b0;
    logic                              i_resetn = 1'b0;
    scciu_pkg::scciu_instr_t           i_instr = '0;
    logic                              i_instr_valid = 1'b0;
    logic [scciu_pkg::DATA_W-1:0]      i_acc = 8'h00;
    logic [scciu_pkg::PC_W-1:0]        i_stack_rdata;
    logic                              i_wake = 1'b0;
    logic [scciu_pkg::PC_W-1:0]        o_pc;
    logic [scciu_pkg::SP_W-1:0]        o_sp;
    scciu_pkg::scciu_stack_t           o_stack;
    logic [scciu_pkg::DATA_W-1:0]      o_acc_wdata;
    logic                              o_busy, o_acc_we, o_gie, o_sys_clk_en;
    logic                              o_osc_en, o_chip_rst, o_wdt_clr, o_flags_we;
    int                                errors = 0;
    int                                tests_run = 0;
    int                                n_acc, n_rst, n_wdt, n_we;
    logic [7:0]                        acc_seen;
    scciu_pkg::scciu_stack_t           st_seen;
    logic [scciu_pkg::PC_W-1:0]        pc_e;

    always #50 i_ref_clk = ~i_ref_clk;

    scciu_top dut_u (.i_ref_clk, .i_resetn, .i_instr, .i_instr_valid, .i_acc,
        .i_stack_rdata, .i_wake, .o_pc, .o_sp, .o_stack, .o_busy, .o_acc_we,
        .o_acc_wdata, .o_gie, .o_sys_clk_en, .o_osc_en, .o_chip_rst, .o_wdt_clr,
        .o_flags_we);
    scciu_stack_mem mem_u (.i_ref_clk, .i_stack(o_stack), .o_rdata(i_stack_rdata));

    task automatic chk_v(input string nm, input logic [15:0] exp, input logic [15:0] got);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // one instruction, then idle cycles while pulses are counted
    task automatic do_op(input scciu_pkg::scciu_op_t op, input logic [9:0] tg,
                         input logic [7:0] im, input int lb);
        int nb;
        int nf;
        nb = 0;
        nf = 0;
        n_acc = 0;
        n_rst = 0;
        n_wdt = 0;
        n_we = 0;
        @(negedge i_ref_clk);
        i_instr = '{op: op, target: tg, imm: im};
        i_instr_valid = 1'b1;
        for (int k = 0; k < 4; k++) begin
            @(negedge i_ref_clk);
            i_instr_valid = 1'b0;
            nb += int'(o_busy === 1'b1);
            nf += int'(o_flags_we !== 1'b0);
            n_rst += int'(o_chip_rst === 1'b1);
            n_wdt += int'(o_wdt_clr === 1'b1);
            if (o_acc_we === 1'b1) begin
                n_acc++;
                acc_seen = o_acc_wdata;
            end
            if (o_stack.we === 1'b1) begin
                n_we++;
                st_seen = o_stack;
            end
        end
        chk_v("busy_count", 16'(lb), 16'(nb));
        chk_v("flag_writes", 16'h0000, 16'(nf));
    endtask

    task automatic t_reset();
        pc_e = 10'h000;
        chk_v("pc", 16'h0000, 16'(o_pc));
        chk_v("sp", 16'h0000, 16'(o_sp));
        chk_v("gie", 16'h0000, 16'(o_gie));
        chk_v("clk_en", 16'h0001, 16'(o_sys_clk_en));
        chk_v("osc_en", 16'h0001, 16'(o_osc_en));
    endtask

    task automatic t_flow();
        do_op(scciu_pkg::OP_NOP, 10'h0AA, 8'h00, 0);
        chk_v("pc", 16'h0001, 16'(o_pc));
        do_op(scciu_pkg::OP_JUMP, 10'h3FF, 8'h00, 1);
        chk_v("pc", 16'h03FF, 16'(o_pc));
        do_op(scciu_pkg::OP_CALL, 10'h155, 8'h00, 1);
        chk_v("pc", 16'h0155, 16'(o_pc));
        chk_v("sp", 16'h0002, 16'(o_sp));
        chk_v("st_writes", 16'h0001, 16'(n_we));
        chk_v("st_addr", 16'h0000, 16'(st_seen.addr));
        chk_v("st_wdata", 16'h0000, 16'(st_seen.wdata));
        do_op(scciu_pkg::OP_CALL, 10'h2AA, 8'h00, 1);
        chk_v("sp", 16'h0004, 16'(o_sp));
        chk_v("st_addr", 16'h0002, 16'(st_seen.addr));
        chk_v("st_wdata", 16'h0156, 16'(st_seen.wdata));
        do_op(scciu_pkg::OP_RET_IMM, 10'h000, 8'hA5, 1);
        chk_v("acc_writes", 16'h0001, 16'(n_acc));
        chk_v("acc_wdata", 16'h00A5, 16'(acc_seen));
        chk_v("sp", 16'h0002, 16'(o_sp));
        chk_v("pc", 16'h0156, 16'(o_pc));
        do_op(scciu_pkg::OP_RET, 10'h000, 8'h00, 1);
        chk_v("acc_writes", 16'h0000, 16'(n_acc));
        chk_v("st_writes", 16'h0000, 16'(n_we));
        chk_v("sp", 16'h0000, 16'(o_sp));
        chk_v("pc", 16'h0000, 16'(o_pc));
        i_acc = 8'hFF;
        do_op(scciu_pkg::OP_PCADD, 10'h000, 8'h00, 1);
        chk_v("pc", 16'h00FF, 16'(o_pc));
        pc_e = 10'h0FF;
    endtask

    task automatic t_gie();
        do_op(scciu_pkg::OP_GIE_ON, 10'h000, 8'h00, 0);
        chk_v("gie", 16'h0001, 16'(o_gie));
        do_op(scciu_pkg::OP_GIE_OFF, 10'h000, 8'h00, 0);
        chk_v("gie", 16'h0000, 16'(o_gie));
        do_op(scciu_pkg::OP_CALL, 10'h0C3, 8'h00, 1);
        do_op(scciu_pkg::OP_RETI, 10'h000, 8'h00, 1);
        chk_v("gie", 16'h0001, 16'(o_gie));
        chk_v("pc", 16'(pc_e + 10'h003), 16'(o_pc));
        chk_v("sp", 16'h0000, 16'(o_sp));
        pc_e = pc_e + 10'h003;
    endtask

    task automatic t_halt();
        scciu_pkg::scciu_op_t hop;
        for (int i = 0; i < 2; i++) begin
            if (i == 0) begin
                hop = scciu_pkg::OP_HALT_SYS;
            end else begin
                hop = scciu_pkg::OP_HALT_CPU;
            end
            do_op(hop, 10'h000, 8'h00, 0);
            pc_e = pc_e + 10'h001;
            chk_v("clk_en", 16'h0000, 16'(o_sys_clk_en));
            chk_v("osc_en", 16'(i), 16'(o_osc_en));
            // a jump offered while halted must be ignored
            do_op(scciu_pkg::OP_JUMP, 10'h011, 8'h00, 0);
            chk_v("pc", 16'(pc_e), 16'(o_pc));
            chk_v("clk_en", 16'h0000, 16'(o_sys_clk_en));
            @(negedge i_ref_clk);
            i_wake = 1'b1;
            @(negedge i_ref_clk);
            i_wake = 1'b0;
            repeat (2) @(negedge i_ref_clk);
            chk_v("clk_en", 16'h0001, 16'(o_sys_clk_en));
            chk_v("osc_en", 16'h0001, 16'(o_osc_en));
            do_op(scciu_pkg::OP_NOP, 10'h000, 8'h00, 0);
            pc_e = pc_e + 10'h001;
            chk_v("pc", 16'(pc_e), 16'(o_pc));
        end
    endtask

    task automatic t_misc();
        do_op(scciu_pkg::OP_WDT_CLR, 10'h000, 8'h00, 0);
        chk_v("wdt_clr", 16'h0001, 16'(n_wdt));
        chk_v("chip_rst", 16'h0000, 16'(n_rst));
        chk_v("gie", 16'h0001, 16'(o_gie));
        do_op(scciu_pkg::OP_SW_RST, 10'h000, 8'h00, 0);
        chk_v("chip_rst", 16'h0001, 16'(n_rst));
        chk_v("wdt_clr", 16'h0000, 16'(n_wdt));
        i_resetn = 1'b0;
        repeat (5) @(negedge i_ref_clk);
        i_resetn = 1'b1;
        t_reset();
    endtask

    task automatic give_verdict();
        if (errors == 0 && tests_run > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    initial begin
        #1_000_000;
        errors++;
        give_verdict();
    end

    initial begin
        repeat (5) @(negedge i_ref_clk);
        i_resetn = 1'b1;
        t_reset();
        t_flow();
        t_gie();
        t_halt();
        t_misc();
        give_verdict();
    end
endmodule // tb
